// >>> verilog/glq_qualifier.sv
// Purpose: Learning and prediction qualifier for a battery gauge
// Assumes: Measurement inputs come from logic on I_MCLK; I_UPDATE marks one gauge update
// Notes: All flags are registered; sticky status bits clear by writing ones
//
// Summary of operation
// - A discharge resistance update is allowed when the voltage drop reaches the minimum drop.
// - Quick capacity learning starts when current is below C over the limit and depth or voltage says so.
// - Learning completes at end of discharge only with more than three starts and depth or voltage near the end.
// - A capacity update is rejected when the error estimated from learning time exceeds the limit.
// - A capacity update is rejected when it moves more than the change limit from the last capacity.
// - Reported remaining capacity is zero at the end-of-discharge voltage, held within 2800 to 3700 mV.
// - Fast resistance scaling is active below the charge threshold or near the end-of-discharge voltage.
// - Simulated resistance rises from zero toward the table value with the settle time constant.
// - The custom current is the simulation rate only for load source 6 with the current model.
// - The custom power is the simulation rate only for load source 6 with the power model.
// - The custom power is scaled by the energy scale setting before use.
// - Load model 0 selects constant current and 1 selects constant power.
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module glq_qualifier
	import glq_pkg::*;
#(
	parameter int ERR_SHIFT = 4
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic [7:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic I_UPDATE,
	input wire logic I_DISCHG,
	input wire logic I_EOD,
	input wire logic [15:0] I_VOLT_MV,
	input wire logic [15:0] I_CURR_MA,
	input wire logic [15:0] I_VDROP_MV,
	input wire logic [7:0] I_DOD_PCT,
	input wire logic [7:0] I_SOC_PCT,
	input wire logic [15:0] I_DESIGN_CAP,
	input wire logic [15:0] I_NEW_CAP,
	input wire logic I_SIM_START,
	input wire logic I_SIM_STEP,
	input wire logic [15:0] I_RES_TABLE,
	input wire logic [19:0] I_AUTO_RATE,
	output logic O_RES_UPD_OK,
	output logic O_LEARN_ACTIVE,
	output logic O_CAP_ACCEPT,
	output logic O_CAP_ZERO,
	output logic O_FAST_SCALE,
	output logic [15:0] O_RES_EFF,
	output logic [19:0] O_SIM_RATE,
	output logic O_RATE_IS_PWR
);
	logic [15:0] res_min_drop_reg;
	logic [7:0] ql_start_depth_reg;
	logic [7:0] ql_end_depth_reg;
	logic [15:0] ql_start_margin_reg;
	logic [15:0] ql_curr_limit_reg;
	logic [7:0] cap_err_limit_reg;
	logic [7:0] cap_chg_limit_reg;
	logic [15:0] eod_volt_reg;
	logic [15:0] scale_margin_reg;
	logic [15:0] settle_const_reg;
	logic [15:0] custom_curr_reg;
	logic [15:0] custom_pwr_reg;
	logic [7:0] scale_soc_reg;
	logic [2:0] load_src_reg;
	glq_model_t load_model_reg;
	logic [3:0] energy_scale_reg;
	logic [ST_WIDTH-1:0] status_reg;
	logic [ST_WIDTH-1:0] status_next;
	logic [7:0] learn_count_reg;
	logic [15:0] learn_time_reg;
	logic [15:0] cap_reg;
	logic [15:0] rdata_next;
	logic [15:0] eod_volt_wr;
	logic [16:0] start_thresh;
	logic [16:0] end_thresh;
	logic [16:0] scale_thresh;
	logic [31:0] curr_scaled;
	logic low_current;
	logic start_cond;
	logic end_cond;
	logic [15:0] err_est;
	logic [15:0] cap_delta;
	logic [23:0] delta_pct;
	logic [23:0] chg_allow;
	logic rej_err;
	logic rej_chg;
	logic finish;
	logic [16:0] res_gap;
	logic [16:0] res_step;
	logic [19:0] pwr_scaled;

	// An out-of-range end-of-discharge voltage setting is pulled into the legal window
	always_comb begin
		if (I_WDATA < EOD_VOLT_MIN) begin
			eod_volt_wr = EOD_VOLT_MIN;
		end else if (I_WDATA > EOD_VOLT_MAX) begin
			eod_volt_wr = EOD_VOLT_MAX;
		end else begin
			eod_volt_wr = I_WDATA;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			res_min_drop_reg <= RST_RES_MIN_DROP;
			ql_start_depth_reg <= RST_QL_START_DEPTH;
			ql_end_depth_reg <= RST_QL_END_DEPTH;
			ql_start_margin_reg <= RST_QL_START_MARGIN;
			ql_curr_limit_reg <= RST_QL_CURR_LIMIT;
			cap_err_limit_reg <= RST_CAP_ERR_LIMIT;
			cap_chg_limit_reg <= RST_CAP_CHG_LIMIT;
			eod_volt_reg <= RST_EOD_VOLT;
			scale_margin_reg <= RST_SCALE_MARGIN;
			settle_const_reg <= RST_SETTLE_CONST;
			custom_curr_reg <= RST_CUSTOM;
			custom_pwr_reg <= RST_CUSTOM;
			scale_soc_reg <= RST_SCALE_SOC;
			load_src_reg <= 3'h0;
			load_model_reg <= GLQ_CONST_CURRENT;
			energy_scale_reg <= RST_ENERGY_SCALE[3:0];
		end else if (I_WR) begin
			unique case (I_ADDR)
				OFS_RES_MIN_DROP: res_min_drop_reg <= I_WDATA;
				OFS_QL_START_DEPTH: ql_start_depth_reg <= I_WDATA[7:0];
				OFS_QL_END_DEPTH: ql_end_depth_reg <= I_WDATA[7:0];
				OFS_QL_START_MARGIN: ql_start_margin_reg <= I_WDATA;
				OFS_QL_CURR_LIMIT: ql_curr_limit_reg <= I_WDATA;
				OFS_CAP_ERR_LIMIT: cap_err_limit_reg <= I_WDATA[7:0];
				OFS_CAP_CHG_LIMIT: cap_chg_limit_reg <= I_WDATA[7:0];
				OFS_EOD_VOLT: eod_volt_reg <= eod_volt_wr;
				OFS_SCALE_MARGIN: scale_margin_reg <= I_WDATA;
				OFS_SETTLE_CONST: settle_const_reg <= I_WDATA;
				OFS_CUSTOM_CURR: custom_curr_reg <= I_WDATA;
				OFS_CUSTOM_PWR: custom_pwr_reg <= I_WDATA;
				OFS_SCALE_SOC: scale_soc_reg <= I_WDATA[7:0];
				OFS_LOAD_CFG: begin
					load_src_reg <= I_WDATA[2:0];
					load_model_reg <= glq_model_t'(I_WDATA[LOAD_MODEL_BIT]);
				end
				OFS_ENERGY_SCALE: energy_scale_reg <= I_WDATA[3:0];
				default: ;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		rdata_next = 16'h0000;
		unique case (I_ADDR)
			OFS_RES_MIN_DROP: rdata_next = res_min_drop_reg;
			OFS_QL_START_DEPTH: rdata_next = {8'h00, ql_start_depth_reg};
			OFS_QL_END_DEPTH: rdata_next = {8'h00, ql_end_depth_reg};
			OFS_QL_START_MARGIN: rdata_next = ql_start_margin_reg;
			OFS_QL_CURR_LIMIT: rdata_next = ql_curr_limit_reg;
			OFS_CAP_ERR_LIMIT: rdata_next = {8'h00, cap_err_limit_reg};
			OFS_CAP_CHG_LIMIT: rdata_next = {8'h00, cap_chg_limit_reg};
			OFS_EOD_VOLT: rdata_next = eod_volt_reg;
			OFS_SCALE_MARGIN: rdata_next = scale_margin_reg;
			OFS_SETTLE_CONST: rdata_next = settle_const_reg;
			OFS_CUSTOM_CURR: rdata_next = custom_curr_reg;
			OFS_CUSTOM_PWR: rdata_next = custom_pwr_reg;
			OFS_SCALE_SOC: rdata_next = {8'h00, scale_soc_reg};
			OFS_LOAD_CFG: rdata_next = {11'h000, load_model_reg, 1'b0, load_src_reg};
			OFS_ENERGY_SCALE: rdata_next = {12'h000, energy_scale_reg};
			OFS_STATUS: rdata_next = {9'h000, status_reg};
			OFS_LEARN_COUNT: rdata_next = {8'h00, learn_count_reg};
			OFS_LEARNED_CAP: rdata_next = cap_reg;
			default: rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RDATA <= 16'h0000;
		end else begin
			O_RDATA <= I_RD ? rdata_next : 16'h0000;
		end
	end

	// Divide-free compare: I * limit < C keeps the path short
	always_comb begin
		start_thresh = {1'b0, eod_volt_reg} + {1'b0, ql_start_margin_reg};
		end_thresh = {1'b0, eod_volt_reg} + {1'b0, QL_END_MARGIN_MV};
		scale_thresh = {1'b0, eod_volt_reg} + {1'b0, scale_margin_reg};
		curr_scaled = I_CURR_MA * ql_curr_limit_reg;
		low_current = curr_scaled < {16'h0000, I_DESIGN_CAP};
		start_cond = I_DISCHG && low_current && ((I_DOD_PCT > ql_start_depth_reg)
			|| ({1'b0, I_VOLT_MV} < start_thresh));
		end_cond = (learn_count_reg > QL_MIN_COUNT) && ((I_DOD_PCT > ql_end_depth_reg)
			|| ({1'b0, I_VOLT_MV} < end_thresh));
		finish = I_EOD && status_reg[ST_LEARN_ACT] && end_cond;
		err_est = learn_time_reg >> ERR_SHIFT;
		rej_err = err_est > {8'h00, cap_err_limit_reg};
		cap_delta = (I_NEW_CAP > cap_reg) ? (I_NEW_CAP - cap_reg) : (cap_reg - I_NEW_CAP);
		delta_pct = cap_delta * PERCENT_FULL;
		chg_allow = cap_reg * cap_chg_limit_reg;
		// First learned value has no previous capacity to compare with
		rej_chg = (cap_reg != 16'h0000) && (delta_pct > chg_allow);
	end

	// Set wins over a software clear in the same cycle
	always_comb begin
		status_next = status_reg;
		if (I_WR && (I_ADDR == OFS_STATUS)) begin
			status_next[ST_LEARN_DONE] = status_reg[ST_LEARN_DONE] & ~I_WDATA[ST_LEARN_DONE];
			status_next[ST_REJ_ERR] = status_reg[ST_REJ_ERR] & ~I_WDATA[ST_REJ_ERR];
			status_next[ST_REJ_CHG] = status_reg[ST_REJ_CHG] & ~I_WDATA[ST_REJ_CHG];
		end
		if (I_UPDATE) begin
			status_next[ST_RES_OK] = I_DISCHG && (I_VDROP_MV >= res_min_drop_reg);
			status_next[ST_CAP_ZERO] = I_VOLT_MV <= eod_volt_reg;
			status_next[ST_FAST_SCALE] = (I_SOC_PCT < scale_soc_reg)
				|| ({1'b0, I_VOLT_MV} < scale_thresh);
			if (!status_reg[ST_LEARN_ACT] && start_cond) begin
				status_next[ST_LEARN_ACT] = 1'b1;
			end
		end
		if (finish) begin
			status_next[ST_LEARN_ACT] = 1'b0;
			status_next[ST_LEARN_DONE] = 1'b1;
			status_next[ST_REJ_ERR] = status_next[ST_REJ_ERR] | rej_err;
			status_next[ST_REJ_CHG] = status_next[ST_REJ_CHG] | rej_chg;
		end else if (I_EOD) begin
			status_next[ST_LEARN_ACT] = 1'b0;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// Learning time counts updates spent measuring
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			learn_count_reg <= 8'h00;
			learn_time_reg <= 16'h0000;
		end else begin
			if (I_UPDATE && !status_reg[ST_LEARN_ACT] && start_cond) begin
				learn_time_reg <= 16'h0000;
				if (learn_count_reg != 8'hff) begin
					learn_count_reg <= learn_count_reg + 8'h01;
				end
			end else if (I_UPDATE && status_reg[ST_LEARN_ACT] && learn_time_reg != 16'hffff) begin
				learn_time_reg <= learn_time_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			cap_reg <= 16'h0000;
			O_CAP_ACCEPT <= 1'b0;
		end else begin
			O_CAP_ACCEPT <= finish && !rej_err && !rej_chg;
			if (finish && !rej_err && !rej_chg) begin
				cap_reg <= I_NEW_CAP;
			end
		end
	end

	// First-order step approximates the exponential rise
	always_comb begin
		res_gap = {1'b0, I_RES_TABLE} - {1'b0, O_RES_EFF};
		if (settle_const_reg == 16'h0000) begin
			res_step = res_gap;
		end else if (res_gap[16]) begin
			res_step = 17'h1ffff - ((17'h1ffff - res_gap) / {1'b0, settle_const_reg});
		end else begin
			res_step = res_gap / {1'b0, settle_const_reg};
		end
		pwr_scaled = custom_pwr_reg * energy_scale_reg;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RES_EFF <= 16'h0000;
		end else if (I_SIM_START) begin
			O_RES_EFF <= 16'h0000;
		end else if (I_SIM_STEP) begin
			O_RES_EFF <= O_RES_EFF + res_step[15:0];
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_SIM_RATE <= 20'h00000;
			O_RATE_IS_PWR <= 1'b0;
		end else begin
			O_RATE_IS_PWR <= load_model_reg == GLQ_CONST_POWER;
			if (load_src_reg == LOAD_SRC_CUSTOM && load_model_reg == GLQ_CONST_CURRENT) begin
				O_SIM_RATE <= {4'h0, custom_curr_reg};
			end else if (load_src_reg == LOAD_SRC_CUSTOM) begin
				O_SIM_RATE <= pwr_scaled;
			end else begin
				O_SIM_RATE <= I_AUTO_RATE;
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RES_UPD_OK <= 1'b0;
			O_LEARN_ACTIVE <= 1'b0;
			O_CAP_ZERO <= 1'b0;
			O_FAST_SCALE <= 1'b0;
		end else begin
			O_RES_UPD_OK <= status_next[ST_RES_OK];
			O_LEARN_ACTIVE <= status_next[ST_LEARN_ACT];
			O_CAP_ZERO <= status_next[ST_CAP_ZERO];
			O_FAST_SCALE <= status_next[ST_FAST_SCALE];
		end
	end
endmodule : glq_qualifier
`default_nettype wire

// >>> common/glq_pkg.sv
// Purpose: Shared constants for the gauge learning qualifier
// Assumes: Eight-bit register offsets, 16-bit register data
// Notes: Reset values are the stored-parameter defaults
`default_nettype none
package glq_pkg;
	localparam logic [7:0] OFS_RES_MIN_DROP = 8'h16;
	localparam logic [7:0] OFS_QL_START_DEPTH = 8'h27;
	localparam logic [7:0] OFS_QL_END_DEPTH = 8'h28;
	localparam logic [7:0] OFS_QL_START_MARGIN = 8'h29;
	localparam logic [7:0] OFS_QL_CURR_LIMIT = 8'h2b;
	localparam logic [7:0] OFS_CAP_ERR_LIMIT = 8'h3d;
	localparam logic [7:0] OFS_CAP_CHG_LIMIT = 8'h3e;
	localparam logic [7:0] OFS_EOD_VOLT = 8'h40;
	localparam logic [7:0] OFS_SCALE_MARGIN = 8'h42;
	localparam logic [7:0] OFS_SETTLE_CONST = 8'h45;
	localparam logic [7:0] OFS_CUSTOM_CURR = 8'h49;
	localparam logic [7:0] OFS_CUSTOM_PWR = 8'h4b;
	localparam logic [7:0] OFS_SCALE_SOC = 8'h68;
	localparam logic [7:0] OFS_LOAD_CFG = 8'h70;
	localparam logic [7:0] OFS_ENERGY_SCALE = 8'h71;
	localparam logic [7:0] OFS_STATUS = 8'h72;
	localparam logic [7:0] OFS_LEARN_COUNT = 8'h73;
	localparam logic [7:0] OFS_LEARNED_CAP = 8'h74;
	localparam logic [15:0] RST_RES_MIN_DROP = 16'h0032;
	localparam logic [7:0] RST_QL_START_DEPTH = 8'h5c;
	localparam logic [7:0] RST_QL_END_DEPTH = 8'h60;
	localparam logic [15:0] RST_QL_START_MARGIN = 16'h00c8;
	localparam logic [15:0] RST_QL_CURR_LIMIT = 16'h0004;
	localparam logic [7:0] RST_CAP_ERR_LIMIT = 8'h0f;
	localparam logic [7:0] RST_CAP_CHG_LIMIT = 8'h1e;
	localparam logic [15:0] RST_EOD_VOLT = 16'h0bb8;
	localparam logic [15:0] RST_SCALE_MARGIN = 16'h00c8;
	localparam logic [15:0] RST_SETTLE_CONST = 16'h01f4;
	localparam logic [15:0] RST_CUSTOM = 16'h0000;
	localparam logic [7:0] RST_SCALE_SOC = 8'h0a;
	localparam logic [7:0] RST_ENERGY_SCALE = 8'h01;
	localparam logic [15:0] EOD_VOLT_MIN = 16'h0af0;
	localparam logic [15:0] EOD_VOLT_MAX = 16'h0e74;
	localparam logic [15:0] QL_END_MARGIN_MV = 16'h0032;
	localparam logic [7:0] QL_MIN_COUNT = 8'h03;
	localparam logic [2:0] LOAD_SRC_CUSTOM = 3'h6;
	localparam logic [7:0] PERCENT_FULL = 8'h64;
	localparam int ST_RES_OK = 0;
	localparam int ST_LEARN_ACT = 1;
	localparam int ST_LEARN_DONE = 2;
	localparam int ST_REJ_ERR = 3;
	localparam int ST_REJ_CHG = 4;
	localparam int ST_CAP_ZERO = 5;
	localparam int ST_FAST_SCALE = 6;
	localparam int ST_WIDTH = 7;
	localparam int LOAD_MODEL_BIT = 4;
	typedef enum logic {
		GLQ_CONST_CURRENT = 1'b0,
		GLQ_CONST_POWER = 1'b1
	} glq_model_t;
endpackage : glq_pkg
`default_nettype wire

// >>> tb/glq_qualifier_asserts.sv
// Purpose: Port checker for the gauge learning qualifier
// Assumes: Thresholds mirrored from bus writes, reset values from the package
// Notes: Only thresholds the flags need are mirrored, to keep the checker small
`default_nettype none
module glq_asserts
	import glq_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic [7:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] O_RDATA,
	input wire logic I_UPDATE,
	input wire logic I_DISCHG,
	input wire logic I_EOD,
	input wire logic [15:0] I_VOLT_MV,
	input wire logic [15:0] I_VDROP_MV,
	input wire logic [7:0] I_SOC_PCT,
	input wire logic I_SIM_START,
	input wire logic O_RES_UPD_OK,
	input wire logic O_LEARN_ACTIVE,
	input wire logic O_CAP_ACCEPT,
	input wire logic O_CAP_ZERO,
	input wire logic O_FAST_SCALE,
	input wire logic [15:0] O_RES_EFF
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] drop_reg, eod_reg, marg_reg;
	logic [7:0] soc_reg;
	logic res_ok, fast_on;
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			drop_reg <= RST_RES_MIN_DROP;
			eod_reg <= RST_EOD_VOLT;
			marg_reg <= RST_SCALE_MARGIN;
			soc_reg <= RST_SCALE_SOC;
		end else if (I_WR) begin
			case (I_ADDR)
				OFS_RES_MIN_DROP: drop_reg <= I_WDATA;
				OFS_SCALE_MARGIN: marg_reg <= I_WDATA;
				OFS_SCALE_SOC: soc_reg <= I_WDATA[7:0];
				OFS_EOD_VOLT: eod_reg <= (I_WDATA < EOD_VOLT_MIN) ? EOD_VOLT_MIN :
					((I_WDATA > EOD_VOLT_MAX) ? EOD_VOLT_MAX : I_WDATA);
				default: ;
			endcase
		end
	end
	assign res_ok = I_DISCHG && (I_VDROP_MV >= drop_reg);
	// Widened sum, the margin may push past 16 bits
	assign fast_on = (I_SOC_PCT < soc_reg) || (17'(I_VOLT_MV) < 17'(eod_reg) + 17'(marg_reg));
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_learn_close;
		!O_LEARN_ACTIVE ##1 !O_CAP_ACCEPT;
	endsequence
	a_res_drop: assert property (I_UPDATE |=> O_RES_UPD_OK == $past(res_ok))
		else $error("resistance update flag wrong");
	a_cap_zero: assert property (I_UPDATE |=> O_CAP_ZERO == $past(I_VOLT_MV <= eod_reg))
		else $error("capacity zero flag wrong");
	a_fast_scale: assert property (I_UPDATE |=> O_FAST_SCALE == $past(fast_on))
		else $error("fast scaling flag wrong");
	a_learn_close: assert property (I_EOD && !I_UPDATE |=> s_learn_close)
		else $error("learning did not close after end of discharge");
	a_accept_cause: assert property (O_CAP_ACCEPT |-> $past(I_EOD) && $past(O_LEARN_ACTIVE))
		else $error("capacity accepted without a finish");
	a_flags_hold: assert property (!I_UPDATE |=> $stable(O_RES_UPD_OK) && $stable(O_FAST_SCALE)
		&& $stable(O_CAP_ZERO))
		else $error("flag moved without an update");
	a_learn_hold: assert property (O_LEARN_ACTIVE && !I_EOD |=> O_LEARN_ACTIVE)
		else $error("learning dropped without end of discharge");
	a_sim_zero: assert property (I_SIM_START |=> O_RES_EFF == 16'h0000)
		else $error("simulated resistance not cleared");
	a_rdata_idle: assert property (!I_RD |=> O_RDATA == 16'h0000)
		else $error("read data outside the read answer cycle");
endmodule : glq_asserts
bind glq_qualifier glq_asserts u_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_UPDATE(I_UPDATE),
	.I_DISCHG(I_DISCHG), .I_EOD(I_EOD), .I_VOLT_MV(I_VOLT_MV), .I_VDROP_MV(I_VDROP_MV),
	.I_SOC_PCT(I_SOC_PCT), .I_SIM_START(I_SIM_START), .O_RES_UPD_OK(O_RES_UPD_OK),
	.O_LEARN_ACTIVE(O_LEARN_ACTIVE), .O_CAP_ACCEPT(O_CAP_ACCEPT), .O_CAP_ZERO(O_CAP_ZERO),
	.O_FAST_SCALE(O_FAST_SCALE), .O_RES_EFF(O_RES_EFF));
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the gauge learning qualifier
// Assumes: One 200 MHz clock, one-cycle bus strobes
// Notes: Error shift set to 0 so long learning runs stay short
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import glq_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, upd = 1'b0, dis = 1'b0, eod = 1'b0;
	logic ss = 1'b0, sst = 1'b0, rok, lact, acc, czero, fscale, ispwr;
	logic [7:0] addr = 8'h00, dod = 8'h00, soc = 8'h00;
	logic [15:0] wd = 16'h0000, volt = 16'h0000, cur = 16'h0000, vdrop = 16'h0000;
	logic [15:0] ncap = 16'h0000, rtab = 16'h0000, dcap = 16'h03e8, rdata, reff;
	logic [19:0] arate = 20'h00000, srate;
	int mismatches = 0, total_checks = 0, r, x;
	integer seed = 32'h395c;
	int mreg [int], dflt [int], msk [int];
	glq_qualifier #(.ERR_SHIFT(0)) dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
		.I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_UPDATE(upd), .I_DISCHG(dis),
		.I_EOD(eod), .I_VOLT_MV(volt), .I_CURR_MA(cur), .I_VDROP_MV(vdrop), .I_DOD_PCT(dod),
		.I_SOC_PCT(soc), .I_DESIGN_CAP(dcap), .I_NEW_CAP(ncap), .I_SIM_START(ss),
		.I_SIM_STEP(sst), .I_RES_TABLE(rtab), .I_AUTO_RATE(arate), .O_RES_UPD_OK(rok),
		.O_LEARN_ACTIVE(lact), .O_CAP_ACCEPT(acc), .O_CAP_ZERO(czero), .O_FAST_SCALE(fscale),
		.O_RES_EFF(reff), .O_SIM_RATE(srate), .O_RATE_IS_PWR(ispwr));
	initial begin
		forever #2.5 clk = ~clk;
	end
	function automatic int rnd(input int n);
		return int'($unsigned($random(seed)) % n);
	endfunction : rnd
	task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input int d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= 16'(d);
		@(posedge clk);
		wr <= 1'b0;
		if (mreg.exists(a)) begin
			mreg[a] = d & msk[a];
		end
		if (a == OFS_EOD_VOLT) begin
			mreg[a] = (d < 2800) ? 2800 : ((d > 3700) ? 3700 : d);
		end
	endtask : wr_reg
	task automatic chk_reg(input logic [7:0] a, input int e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), 20'(rdata), 20'(e));
	endtask : chk_reg
	task automatic do_upd(input int d_is, v, c, drp, dd, sc, u, e);
		int ef;
		@(posedge clk);
		{upd, eod, dis} <= {u[0], e[0], d_is[0]};
		{volt, cur, vdrop, dod, soc} <= {16'(v), 16'(c), 16'(drp), 8'(dd), 8'(sc)};
		@(posedge clk);
		{upd, eod} <= 2'b00;
		#1;
		ef = (sc < mreg[OFS_SCALE_SOC]) || (v < mreg[OFS_EOD_VOLT] + mreg[OFS_SCALE_MARGIN]);
		if (u) begin
			chk("res ok", 20'(rok), 20'(d_is && drp >= mreg[OFS_RES_MIN_DROP]));
			chk("cap zero", 20'(czero), 20'(v <= mreg[OFS_EOD_VOLT]));
			chk("fast scale", 20'(fscale), 20'(ef));
		end
	endtask : do_upd
	task automatic learn(input int n, cp, ds, vs, de, ve, e);
		@(posedge clk);
		ncap <= 16'(cp);
		do_upd(1, vs, 10, 0, ds, 50, 1, 0);
		chk("learn start", 20'(lact), 20'h1);
		repeat (n - 1) do_upd(1, 3800, 10, 0, ds, 50, 1, 0);
		do_upd(1, ve, 10, 0, de, 50, 0, 1);
		chk("cap accept", 20'(acc), 20'(e));
		chk("learn end", 20'(lact), 20'h0);
	endtask : learn
	task automatic conclude();
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	initial begin
		#150us;
		mismatches++;
		conclude();
	end
	initial begin
		mreg = '{OFS_RES_MIN_DROP: RST_RES_MIN_DROP, OFS_QL_START_DEPTH: RST_QL_START_DEPTH,
			OFS_QL_END_DEPTH: RST_QL_END_DEPTH, OFS_QL_START_MARGIN: RST_QL_START_MARGIN,
			OFS_QL_CURR_LIMIT: RST_QL_CURR_LIMIT, OFS_CAP_ERR_LIMIT: RST_CAP_ERR_LIMIT,
			OFS_CAP_CHG_LIMIT: RST_CAP_CHG_LIMIT, OFS_EOD_VOLT: RST_EOD_VOLT,
			OFS_SCALE_MARGIN: RST_SCALE_MARGIN, OFS_SETTLE_CONST: RST_SETTLE_CONST,
			OFS_CUSTOM_CURR: RST_CUSTOM, OFS_CUSTOM_PWR: RST_CUSTOM, OFS_SCALE_SOC: RST_SCALE_SOC,
			OFS_LOAD_CFG: 0, OFS_ENERGY_SCALE: RST_ENERGY_SCALE};
		msk = '{OFS_QL_START_DEPTH: 255, OFS_QL_END_DEPTH: 255, OFS_CAP_ERR_LIMIT: 255,
			OFS_CAP_CHG_LIMIT: 255, OFS_SCALE_SOC: 255, OFS_LOAD_CFG: 'h17,
			OFS_ENERGY_SCALE: 'hf, default: 'hffff};
		dflt = mreg;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		foreach (mreg[k]) chk_reg(8'(k), mreg[k]);
		wr_reg(8'h00, 'hffff);
		chk_reg(8'h00, 0);
		chk_reg(8'hff, 0);
		foreach (mreg[k]) begin
			wr_reg(8'(k), rnd(65536));
			chk_reg(8'(k), mreg[k]);
		end
		wr_reg(OFS_EOD_VOLT, 0);
		chk_reg(OFS_EOD_VOLT, 2800);
		wr_reg(OFS_EOD_VOLT, 'hffff);
		chk_reg(OFS_EOD_VOLT, 3700);
		foreach (dflt[k]) wr_reg(8'(k), dflt[k]);
		$display("test registers done");
		wr_reg(OFS_RES_MIN_DROP, 20 + rnd(100));
		wr_reg(OFS_SCALE_SOC, 5 + rnd(20));
		wr_reg(OFS_SCALE_MARGIN, rnd(400));
		for (int k = 0; k < 40; k++) begin
			x = (k % 2) ? mreg[OFS_EOD_VOLT] - 1 : mreg[OFS_EOD_VOLT] + mreg[OFS_SCALE_MARGIN] - 3;
			// Current sits at C over the limit or just above, never strictly below
			do_upd(rnd(2), x + rnd(7), 250 + rnd(4), mreg[OFS_RES_MIN_DROP] - 2 + rnd(5), 95,
				mreg[OFS_SCALE_SOC] - 2 + rnd(5), 1, 0);
			chk("no learn", 20'(lact), 20'h0);
		end
		$display("test flags done");
		learn(2, 1000, 95, 3800, 97, 3800, 0);
		learn(2, 1000, 10, 3100, 97, 3800, 0);
		learn(2, 1000, 95, 3800, 97, 3800, 0);
		learn(2, 1000, 95, 3800, 90, 3800, 0);
		learn(2, 1000, 95, 3800, 90, 3040, 1);
		chk_reg(OFS_LEARNED_CAP, 1000);
		learn(2, 1400, 95, 3800, 97, 3800, 0);
		learn(30, 1100, 95, 3800, 97, 3800, 0);
		learn(2, 1250, 95, 3800, 97, 3800, 1);
		chk_reg(OFS_LEARN_COUNT, 8);
		chk_reg(OFS_STATUS, 'h1c);
		wr_reg(OFS_STATUS, 'h1c);
		chk_reg(OFS_STATUS, 0);
		$display("test learning done");
		@(posedge clk);
		rtab <= 16'(rnd(4096));
		wr_reg(OFS_SETTLE_CONST, 4);
		@(posedge clk);
		{ss, sst} <= 2'b10;
		r = 0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			{ss, sst} <= 2'b01;
			@(posedge clk);
			{ss, sst} <= 2'b00;
			#1;
			r = (k == 11) ? int'(rtab) : r + (int'(rtab) - r) / 4;
			chk("res eff", 20'(reff), 20'(r));
			if (k == 10) wr_reg(OFS_SETTLE_CONST, 0);
		end
		$display("test simulation done");
		@(posedge clk);
		arate <= 20'(rnd(1 << 20));
		wr_reg(OFS_ENERGY_SCALE, 3);
		wr_reg(OFS_CUSTOM_CURR, rnd(32768));
		wr_reg(OFS_CUSTOM_PWR, rnd(32768));
		for (int k = 0; k < 16; k++) begin
			wr_reg(OFS_LOAD_CFG, (k % 8) | ((k / 8) << LOAD_MODEL_BIT));
			repeat (2) @(posedge clk);
			#1;
			x = (k == 6) ? mreg[OFS_CUSTOM_CURR] : ((k == 14) ? mreg[OFS_CUSTOM_PWR] * 3 : arate);
			chk("sim rate", srate, 20'(x));
			chk("rate kind", 20'(ispwr), 20'(k / 8));
		end
		$display("test rate done");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		chk_reg(OFS_LOAD_CFG, 0);
		conclude();
	end
endmodule : testbench
`default_nettype wire
